// file: gcr_4b5b_tape_codec.sv
// Registered 4b/5b group-code encoder/decoder for a streaming tape formatter
`default_nettype none

module gcr_4b5b_tape_codec
  import gcr_codec_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             enable_n,
  input  wire logic                             mode_sel_hi,
  input  wire logic                             mode_sel_lo,
  input  wire logic                             nibble_in_b0,
  input  wire logic                             nibble_in_b1,
  input  wire logic                             nibble_in_b2,
  input  wire logic                             nibble_in_b3,
  input  wire logic                             serial_in,
  input  wire logic                             flag_control,
  input  wire logic [gcr_codec_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [gcr_codec_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                             reg_write,
  input  wire logic                             reg_read,
  output logic                                  code_stage_1,
  output logic                                  code_stage_2,
  output logic                                  code_stage_3,
  output logic                                  code_stage_top,
  output logic                                  serial_out_stage,
  output logic                                  bad_code_flag_n,
  output logic                                  sync_pattern_hit_n,
  output logic      [gcr_codec_pkg::DATA_W-1:0] reg_rdata,
  output logic                                  irq
);

  // Six storage bits only; the flag is kept in its pin polarity
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              flag_n;
  } codec_state_t;

  codec_state_t cur;
  codec_state_t next_cur;

  logic [NIBBLE_W-1:0] nibble;
  logic [CODE_W-1:0]   enc_code;
  logic [NIBBLE_W-1:0] dec_nibble;
  logic                code_bad;
  logic [1:0]          mode;
  logic [EVT_W-1:0]    events;
  logic [EVT_W-1:0]    live;
  logic                sync_hit;

  assign nibble = {nibble_in_b3, nibble_in_b2, nibble_in_b1, nibble_in_b0};
  assign mode   = {mode_sel_hi, mode_sel_lo};

  gcr_code_map u_map (
    .nibble     (nibble),
    .code       (cur.code),
    .enc_code   (enc_code),
    .dec_nibble (dec_nibble),
    .code_bad   (code_bad)
  );

  always_comb begin
    next_cur = cur;
    if (!enable_n) begin
      case (mode)
        MODE_SHIFT_IN: begin
          // Serial data enters the low end and climbs toward the top
          next_cur.code = {cur.code[CODE_W-2:0], serial_in};
        end
        MODE_SHIFT_OUT: begin
          next_cur.code = {cur.code[POS_SER], cur.code[CODE_W-1:1]};
        end
        MODE_DECODE: begin
          // The serial stage keeps sampling the line while decoding
          next_cur.code = {dec_nibble, serial_in};
        end
        MODE_ENCODE: begin
          next_cur.code = enc_code;
        end
        default: next_cur.code = cur.code;
      endcase
    end
    // Clear from the partner wins even while the register holds
    if (!flag_control) begin
      next_cur.flag_n = FLAG_N_RESET;
    end else if (!enable_n && mode == MODE_DECODE && code_bad) begin
      next_cur.flag_n = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{code: CODE_RESET, flag_n: FLAG_N_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_hit = (cur.code == SYNC_PATTERN);

  // Events: flag newly set, and sync pattern newly present
  assign events[EVT_BAD_CODE] = cur.flag_n & ~next_cur.flag_n;
  assign events[EVT_SYNC]     = ~sync_hit & (next_cur.code == SYNC_PATTERN);
  assign live[EVT_BAD_CODE]   = ~cur.flag_n;
  assign live[EVT_SYNC]       = sync_hit;

  gcr_event_regs u_evt (
    .clk       (clk),
    .rst_b     (rst_b),
    .events    (events),
    .live      (live),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_write (reg_write),
    .reg_read  (reg_read),
    .reg_rdata (reg_rdata),
    .irq       (irq)
  );

  assign serial_out_stage   = cur.code[POS_SER];
  assign code_stage_1       = cur.code[POS_S1];
  assign code_stage_2       = cur.code[POS_S2];
  assign code_stage_3       = cur.code[POS_S3];
  assign code_stage_top     = cur.code[POS_TOP];
  assign bad_code_flag_n    = cur.flag_n;
  // Combinational from the five stages, so it follows the register with no delay
  assign sync_pattern_hit_n = ~sync_hit;

endmodule : gcr_4b5b_tape_codec

`default_nettype wire

// file: gcr_codec_pkg.sv
// Constants, code table and mode codes for the 4b/5b tape codec
//
// Operation
// - Enable high holds the five code bits unchanged; flag still clears with control low
// - Exactly one function selected per clock
// - Five shared code bits plus one flag
// - First code bit zero when b3 and (b0|b1)
// - Code loaded as printed, LSB sent first
// - Shift-in: serial bit enters low, stages move up
// - Five shift-in clocks leave MSB on top
// - Shift-out rotates end-around, opposite to shift-in
// - Unused codes decode to nibble zero
// - Decode sets flag on codes outside table
// - Flag updates only with control high, else cleared
// - Flag output pin is active low
// - Sync output asserts when all five ones
// - Sixteen nibbles map to fixed five-bit codes
`default_nettype none

package gcr_codec_pkg;

  localparam int CODE_W   = 5;
  localparam int NIBBLE_W = 4;
  localparam int EVT_W    = 2;
  localparam int ADDR_W   = 2;
  localparam int DATA_W   = 8;

  // Mode inputs {mode_sel_hi, mode_sel_lo}
  localparam logic [1:0] MODE_SHIFT_IN  = 2'h0;
  localparam logic [1:0] MODE_SHIFT_OUT = 2'h1;
  localparam logic [1:0] MODE_DECODE    = 2'h2;
  localparam logic [1:0] MODE_ENCODE    = 2'h3;

  // Bit positions inside the code register {top, stage3, stage2, stage1, serial_out}
  localparam int POS_SER  = 0;
  localparam int POS_S1   = 1;
  localparam int POS_S2   = 2;
  localparam int POS_S3   = 3;
  localparam int POS_TOP  = 4;

  // Register port map
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR  = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_LIVE   = 2'h3;

  // Event bits
  localparam int EVT_BAD_CODE = 0;
  localparam int EVT_SYNC     = 1;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RESET   = 5'h00;
  localparam logic              FLAG_N_RESET = 1'b1;
  localparam logic [EVT_W-1:0]  EVT_RESET    = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET  = 8'h00;

  localparam logic [CODE_W-1:0] SYNC_PATTERN = 5'h1F;

  // Leftmost printed code bit sits in the top stage
  function automatic logic [CODE_W-1:0] gcr_encode(input logic [NIBBLE_W-1:0] n);
    logic [CODE_W-1:0] c;
    c = 5'h00;
    case (n)
      4'h0: c = 5'h19;
      4'h1: c = 5'h1B;
      4'h2: c = 5'h12;
      4'h3: c = 5'h13;
      4'h4: c = 5'h1D;
      4'h5: c = 5'h15;
      4'h6: c = 5'h16;
      4'h7: c = 5'h17;
      4'h8: c = 5'h1A;
      4'h9: c = 5'h09;
      4'hA: c = 5'h0A;
      4'hB: c = 5'h0B;
      4'hC: c = 5'h1E;
      4'hD: c = 5'h0D;
      4'hE: c = 5'h0E;
      4'hF: c = 5'h0F;
      default: c = 5'h00;
    endcase
    return c;
  endfunction : gcr_encode

endpackage : gcr_codec_pkg

`default_nettype wire

// file: gcr_code_map.sv
// Combinational nibble/code conversion and code validity check
`default_nettype none

module gcr_code_map
  import gcr_codec_pkg::*;
(
  input  wire logic [gcr_codec_pkg::NIBBLE_W-1:0] nibble,
  input  wire logic [gcr_codec_pkg::CODE_W-1:0]   code,
  output logic      [gcr_codec_pkg::CODE_W-1:0]   enc_code,
  output logic      [gcr_codec_pkg::NIBBLE_W-1:0] dec_nibble,
  output logic                                    code_bad
);

  always_comb begin
    enc_code = gcr_encode(nibble);
    // Unused patterns fall out as zero and flag bad
    dec_nibble = 4'h0;
    code_bad   = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (gcr_encode(4'(i)) == code) begin
        dec_nibble = 4'(i);
        code_bad   = 1'b0;
      end
    end
  end

endmodule : gcr_code_map

`default_nettype wire

// file: gcr_event_regs.sv
// Sticky event status, enable and clear registers with interrupt output
`default_nettype none

module gcr_event_regs
  import gcr_codec_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic [gcr_codec_pkg::EVT_W-1:0]   events,
  input  wire logic [gcr_codec_pkg::EVT_W-1:0]   live,
  input  wire logic [gcr_codec_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [gcr_codec_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [gcr_codec_pkg::DATA_W-1:0]  reg_rdata,
  output logic                                   irq
);

  typedef struct packed {
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  enable;
    logic [DATA_W-1:0] rdata;
    logic              irq;
  } ev_state_t;

  ev_state_t cur;
  ev_state_t next_cur;

  always_comb begin
    logic [EVT_W-1:0] clr;
    clr      = '0;
    next_cur = cur;
    if (reg_write && reg_addr == ADDR_CLEAR) begin
      clr = reg_wdata[EVT_W-1:0];
    end
    if (reg_write && reg_addr == ADDR_ENABLE) begin
      next_cur.enable = reg_wdata[EVT_W-1:0];
    end
    // A new event in the clearing cycle survives
    next_cur.status = (cur.status & ~clr) | events;
    next_cur.rdata  = RDATA_RESET;
    if (reg_read) begin
      case (reg_addr)
        ADDR_STATUS: next_cur.rdata = {{(DATA_W-EVT_W){1'b0}}, cur.status};
        ADDR_ENABLE: next_cur.rdata = {{(DATA_W-EVT_W){1'b0}}, cur.enable};
        ADDR_LIVE:   next_cur.rdata = {{(DATA_W-EVT_W){1'b0}}, live};
        default:     next_cur.rdata = RDATA_RESET;
      endcase
    end
    next_cur.irq = |(next_cur.status & next_cur.enable);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{status: EVT_RESET, enable: EVT_RESET, rdata: RDATA_RESET, irq: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign irq       = cur.irq;

endmodule : gcr_event_regs

`default_nettype wire

// file: gcr_codec_monitor.sv
// Port checker for the 4b/5b tape codec
`default_nettype none
module gcr_codec_monitor
  import gcr_codec_pkg::*;
(
  input wire logic                             clk,
  input wire logic                             rst_b,
  input wire logic                             enable_n,
  input wire logic                             mode_sel_hi,
  input wire logic                             mode_sel_lo,
  input wire logic                             nibble_in_b0,
  input wire logic                             nibble_in_b1,
  input wire logic                             nibble_in_b3,
  input wire logic                             serial_in,
  input wire logic                             flag_control,
  input wire logic                             reg_read,
  input wire logic                             code_stage_1,
  input wire logic                             code_stage_2,
  input wire logic                             code_stage_3,
  input wire logic                             code_stage_top,
  input wire logic                             serial_out_stage,
  input wire logic                             bad_code_flag_n,
  input wire logic                             sync_pattern_hit_n,
  input wire logic [gcr_codec_pkg::DATA_W-1:0] reg_rdata
);
  logic [4:0] c, shin, rot;
  logic [1:0] m;
  logic       top;
  assign c = {code_stage_top, code_stage_3, code_stage_2, code_stage_1, serial_out_stage};
  assign m = {mode_sel_hi, mode_sel_lo};
  assign shin = {c[3:0], serial_in};
  assign rot = {c[0], c[4:1]};
  assign top = !(nibble_in_b3 && (nibble_in_b0 || nibble_in_b1));
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_hold_code: assert property (enable_n |=> $stable(c))
    else $error("code moved while disabled");
  a_shift_in: assert property (!enable_n && m == 2'h0 |=> c == $past(shin))
    else $error("shift-in wrong");
  a_rotate_out: assert property (!enable_n && m == 2'h1 |=> c == $past(rot))
    else $error("shift-out rotate wrong");
  a_encode_top: assert property (!enable_n && m == 2'h3 |=> code_stage_top == $past(top))
    else $error("first code bit wrong");
  a_decode_low: assert property (!enable_n && m == 2'h2 |=> serial_out_stage == $past(serial_in))
    else $error("decode low stage wrong");
  a_flag_clear: assert property (!flag_control |=> bad_code_flag_n)
    else $error("flag not cleared");
  a_flag_keep: assert property (flag_control && (enable_n || m != 2'h2)
    |=> $stable(bad_code_flag_n)) else $error("flag changed outside decode");
  a_flag_set: assert property (flag_control && !enable_n && m == 2'h2 && c == 5'h1F
    |=> !bad_code_flag_n) else $error("sync code not flagged");
  a_sync_hit: assert property (sync_pattern_hit_n == !(&c))
    else $error("sync output wrong");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : gcr_codec_monitor
bind gcr_4b5b_tape_codec gcr_codec_monitor i_gcr_codec_monitor (.clk, .rst_b, .enable_n,
  .mode_sel_hi, .mode_sel_lo, .nibble_in_b0, .nibble_in_b1, .nibble_in_b3, .serial_in,
  .flag_control, .reg_read, .code_stage_1, .code_stage_2, .code_stage_3, .code_stage_top,
  .serial_out_stage, .bad_code_flag_n, .sync_pattern_hit_n, .reg_rdata);
`default_nettype wire

// file: tape_feed.sv
// Read data separator model feeding serial code bits
`default_nettype none
module tape_feed (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       load,
  input  wire logic       shift,
  input  wire logic [4:0] word,
  output logic            serial_in
);
  logic [4:0] sr;
  assign serial_in = sr[4];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sr <= 5'h00;
    else if (load) sr <= word;
    // Inverted fill so a stale bit never repeats
    else if (shift) sr <= {sr[3:0], ~sr[4]};
  end
endmodule : tape_feed
`default_nettype wire

// file: gcr_4b5b_tape_codec_bench.sv
// Self-checking bench for the 4b/5b tape codec
`default_nettype none
module gcr_4b5b_tape_codec_bench
  import gcr_codec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, enable_n, mode_sel_hi, mode_sel_lo, flag_control, reg_write, reg_read;
  logic load, shift, serial_in, irq, bad_code_flag_n, sync_pattern_hit_n;
  logic [3:0] nib;
  logic [4:0] word, code, held;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rdv;
  logic [4:0] gcr [16] = '{5'h19, 5'h1B, 5'h12, 5'h13, 5'h1D, 5'h15, 5'h16, 5'h17,
                           5'h1A, 5'h09, 5'h0A, 5'h0B, 5'h1E, 5'h0D, 5'h0E, 5'h0F};
  int n_mismatch, num_checks, cyc;
  gcr_4b5b_tape_codec i_gcr_4b5b_tape_codec (.clk, .rst_b, .enable_n, .mode_sel_hi,
    .mode_sel_lo, .nibble_in_b0(nib[0]), .nibble_in_b1(nib[1]), .nibble_in_b2(nib[2]),
    .nibble_in_b3(nib[3]), .serial_in, .flag_control, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .code_stage_1(code[1]), .code_stage_2(code[2]), .code_stage_3(code[3]),
    .code_stage_top(code[4]), .serial_out_stage(code[0]), .bad_code_flag_n,
    .sync_pattern_hit_n, .reg_rdata, .irq);
  tape_feed i_tape_feed (.clk, .rst_b, .load, .shift, .word, .serial_in);
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic en, input logic [1:0] m);
    @(posedge clk);
    enable_n <= en;
    {mode_sel_hi, mode_sel_lo} <= m;
  endtask : op
  task automatic settle;
    op(1'b1, 2'h0);
    shift <= 1'b0;
    #1;
  endtask : settle
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= w;
    reg_read <= !w;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : access
  task automatic feed(input logic [4:0] w);
    @(posedge clk);
    word <= w;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    shift <= 1'b1;
    enable_n <= 1'b0;
    {mode_sel_hi, mode_sel_lo} <= MODE_SHIFT_IN;
    repeat (4) @(posedge clk);
    settle();
  endtask : feed
  task automatic t_encode;
    for (int n = 0; n < 16; n++) begin
      op(1'b0, MODE_ENCODE);
      nib <= n[3:0];
      settle();
      chk(code, gcr[n]);
      op(1'b0, MODE_SHIFT_OUT);
      settle();
      chk(code, {gcr[n][0], gcr[n][4:1]});
      op(1'b0, MODE_SHIFT_OUT);
      repeat (3) @(posedge clk);
      settle();
      chk(code, gcr[n]);
    end
    $display("encode test done");
  endtask : t_encode
  task automatic t_read;
    for (int n = 0; n < 16; n++) begin
      feed(gcr[n]);
      chk(code, gcr[n]);
      op(1'b0, MODE_DECODE);
      settle();
      chk(code[4:1], n[3:0]);
      chk(bad_code_flag_n, 1'b1);
    end
    $display("decode test done");
  endtask : t_read
  task automatic t_flag;
    feed(5'h1F);
    chk(sync_pattern_hit_n, 1'b0);
    access(1'b1, ADDR_ENABLE, 8'h01);
    op(1'b0, MODE_DECODE);
    settle();
    chk(bad_code_flag_n, 1'b0);
    chk(irq, 1'b1);
    access(1'b0, ADDR_STATUS, 8'h00);
    chk(rdv[0], 1'b1);
    chk(rdv, 8'h03);
    access(1'b0, ADDR_LIVE, 8'h00);
    chk(rdv, 8'h01);
    held = code;
    repeat (3) @(posedge clk);
    chk(code, held);
    @(posedge clk) flag_control <= 1'b0;
    @(posedge clk) flag_control <= 1'b1;
    #1 chk(bad_code_flag_n, 1'b1);
    // Register now holds 0000x, outside the table
    op(1'b0, MODE_DECODE);
    settle();
    chk(bad_code_flag_n, 1'b0);
    @(posedge clk) flag_control <= 1'b0;
    @(posedge clk) flag_control <= 1'b1;
    #1 chk(bad_code_flag_n, 1'b1);
    access(1'b1, ADDR_CLEAR, 8'h03);
    chk(irq, 1'b0);
    access(1'b0, ADDR_CLEAR, 8'h00);
    chk(rdv, 8'h00);
    access(1'b0, ADDR_ENABLE, 8'h00);
    chk(rdv, 8'h01);
    $display("flag test done");
  endtask : t_flag
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_b, mode_sel_hi, mode_sel_lo, reg_write, reg_read, load, shift} = '0;
    {enable_n, flag_control} = 2'h3;
    {nib, word, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_encode();
    t_read();
    t_flag();
    summarize();
  end
  // Run is about 320 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
endmodule : gcr_4b5b_tape_codec_bench
`default_nettype wire
